// file: rtl/petg_consts.vh
`ifndef PETG_CONSTS_VH
`define PETG_CONSTS_VH

// Fine edge grid: positions per pixel period and derived values.
`define PETG_STEPS          6'h30
`define PETG_LAST_STEP      6'h2F
`define PETG_HALF_STEPS     7'h18
`define PETG_STEPS_W7       7'h30
`define PETG_QUAD_SPAN_MAX  4'hB
`define PETG_QUAD0_BASE     6'h00
`define PETG_QUAD1_BASE     6'h0C
`define PETG_QUAD2_BASE     6'h18
`define PETG_QUAD3_BASE     6'h24
`define PETG_RG_RISE_POS    6'h00

// Output clock phase table, rising and falling positions.
`define PETG_OCLK_P6        6'h06
`define PETG_OCLK_P16       6'h10
`define PETG_OCLK_P26       6'h1A
`define PETG_OCLK_P36       6'h24

// Control register addresses on the 3-wire port.
`define PETG_ADDR_SAMPLE    8'h02
`define PETG_ADDR_HCLK      8'h03
`define PETG_ADDR_DRIVE     8'h04
`define PETG_ADDR_STANDBY   8'h05
`define PETG_ADDR_GAIN      8'h0E
`define PETG_ADDR_MASTER_CLOCK_DIVIDE    8'hD5

// Field layout inside the 24-bit data word.
`define PETG_F_REFLOC       5:0
`define PETG_F_DATLOC       11:6
`define PETG_F_WORDPH       17:12
`define PETG_F_OCLKPH       23:18
`define PETG_F_RGFALL       5:0
`define PETG_F_HARISE       11:6
`define PETG_F_HADRV        2:0
`define PETG_F_HBDRV        5:3
`define PETG_F_RESET_GATE_DRIVE_STRENGTH        8:6
`define PETG_F_FRONT_END_STANDBY      0
`define PETG_F_DIGITAL_STANDBY      1
`define PETG_F_GAIN         9:0
`define PETG_F_MASTER_CLOCK_DIVIDE       1:0

// Serial frame: 8 address bits then 24 data bits.
`define PETG_FRAME_BITS     6'h20
`define PETG_DRV_OFF        3'h0

// Reset values.
`define PETG_RST_LOC        6'h00
`define PETG_RST_DRV        3'h0
`define PETG_RST_GAIN       10'h000
`define PETG_RST_DIV        2'h0

`endif

// file: rtl/petg_serial_rx.v
`timescale 1ns/1ps
`include "petg_consts.vh"

module petg_serial_rx
(
  input  wire        core_clk,    // Core clock
  input  wire        rst_b,       // Synchronous reset, low active
  input  wire        clkEn,       // Freezes state while low
  input  wire        serialClock, // Serial bit clock
  input  wire        serialLoad,  // Frame select, low during a frame
  input  wire        serialData,  // Serial data, MSB first
  output reg         wrStrobe,    // One-cycle write pulse
  output reg  [7:0]  wrAddr,      // Write address
  output reg  [23:0] wrData       // Write data
);

  reg        sckPrev;
  reg        slPrev;
  reg [31:0] shiftReg;
  reg [5:0]  bitCnt;

  // Frames of any other length are dropped, so long system writes never hit control fields.
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sckPrev  <= 1'b0;
      slPrev   <= 1'b1;
      shiftReg <= 32'h0000_0000;
      bitCnt   <= 6'h00;
      wrStrobe <= 1'b0;
      wrAddr   <= 8'h00;
      wrData   <= 24'h00_0000;
    end
    else if (clkEn)
    begin
      sckPrev  <= serialClock;
      slPrev   <= serialLoad;
      wrStrobe <= 1'b0;
      if (!serialLoad && serialClock && !sckPrev)
      begin
        shiftReg <= {shiftReg[30:0], serialData};
        if (bitCnt != 6'h3F)
        begin
          bitCnt <= bitCnt + 6'h01;
        end
      end
      if (serialLoad && !slPrev)
      begin
        bitCnt <= 6'h00;
        if (bitCnt == `PETG_FRAME_BITS)
        begin
          wrStrobe <= 1'b1;
          wrAddr   <= shiftReg[31:24];
          wrData   <= shiftReg[23:0];
        end
      end
    end
  end

endmodule

// file: rtl/petg_phase_gen.v
`timescale 1ns/1ps
`include "petg_consts.vh"

module petg_phase_gen
(
  input  wire       core_clk,      // Core clock, one fine step per cycle
  input  wire       rst_b,         // Synchronous reset, low active
  input  wire       clkEn,         // Freezes state while low
  input  wire       masterClockIn, // Master clock, sampled
  input  wire [1:0] divSel,        // Master clock divide code
  input  wire       resync,        // Restarts divider and grid
  output reg  [5:0] finePos,       // Fine position 0 to 47
  output reg        pixelStart     // Pulse at each pixel period start
);

  reg       mcPrev;
  reg [1:0] divCnt;
  wire      mcRise;
  wire      divTick;

  assign mcRise  = masterClockIn && !mcPrev;
  // Code 0 passes every edge; codes 1..3 divide by 2..4.
  assign divTick = mcRise && (divCnt == divSel);

  always @(posedge core_clk)
  begin
    if (!rst_b || resync)
    begin
      mcPrev     <= 1'b0;
      divCnt     <= 2'h0;
      finePos    <= 6'h00;
      pixelStart <= 1'b0;
    end
    else if (clkEn)
    begin
      mcPrev     <= masterClockIn;
      pixelStart <= divTick;
      if (mcRise)
      begin
        divCnt <= divTick ? 2'h0 : divCnt + 2'h1;
      end
      if (divTick)
      begin
        finePos <= 6'h00;
      end
      else if (finePos == `PETG_LAST_STEP)
      begin
        finePos <= 6'h00;
      end
      else
      begin
        finePos <= finePos + 6'h01;
      end
    end
  end

endmodule

// file: rtl/petg_top.v
`timescale 1ns/1ps
`include "petg_consts.vh"

module petg_top
(
  input  wire       core_clk,         // Core clock, 40 MHz
  input  wire       rst_b,            // Synchronous reset, low active
  input  wire       clkEn,            // Clock enable, freezes state when low
  input  wire       masterClockIn,    // Master clock input
  input  wire       serialClock,      // 3-wire port clock
  input  wire       serialLoad,       // 3-wire port load
  input  wire       serialData,       // 3-wire port data
  input  wire [9:0] pixelDataIn,      // Converted pixel word
  output reg        resetGatePulse,   // Reset-gate pulse level
  output reg        resetGateOe,      // Reset-gate driver enable
  output reg        horizClockA,      // Horizontal clock A level
  output reg        horizClockAOe,    // Horizontal clock A driver enable
  output reg        horizClockB,      // Horizontal clock B level
  output reg        horizClockBOe,    // Horizontal clock B driver enable
  output reg  [2:0] horizADrive,      // Horizontal A drive strength
  output reg  [2:0] horizBDrive,      // Horizontal B drive strength
  output reg  [2:0] resetGateDrive,   // Reset-gate drive strength
  output reg        refSampleStrobe,  // Reference-level sample strobe
  output reg        levelSampleStrobe,// Data-level sample strobe
  output reg  [9:0] outputWord,       // Output data word
  output reg        outputWordWindow, // Output word phase window
  output reg        pixelOutputClock, // Output pixel clock
  output reg  [9:0] amplifierGain,    // Amplifier gain setting
  output reg        frontEndStandby,  // Front-end standby bit
  output reg        digitalStandby,   // Digital standby bit
  output reg  [5:0] finePosition      // Current fine position
);

  reg  [5:0] refSampleLocReg;
  reg  [5:0] dataSampleLocReg;
  reg  [5:0] outputWordPhaseReg;
  reg  [5:0] outputClockPhaseReg;
  reg  [5:0] resetGateFallLocReg;
  reg  [5:0] horizARiseLocReg;
  reg  [2:0] horizADriveReg;
  reg  [2:0] horizBDriveReg;
  reg  [2:0] resetGateDriveReg;
  reg        frontEndStandbyReg;
  reg        digitalStandbyReg;
  reg  [9:0] amplifierGainReg;
  reg  [1:0] masterClockDivideReg;

  wire       wrStrobe;
  wire [7:0] wrAddr;
  wire [23:0] wrData;
  wire [5:0] pos;
  wire       pixelStart;
  wire       resync;

  wire [5:0] rgFallPos;
  wire [5:0] haRisePos;
  wire [5:0] haFallPos;
  wire [5:0] refPos;
  wire [5:0] datPos;
  wire [5:0] wordRisePos;
  wire [5:0] wordFallPos;
  reg  [5:0] oclkRisePos;
  reg  [5:0] oclkFallPos;
  wire       horizANext;

  // Quadrant decode; offsets above 11 clamp to the quadrant's last position.
  function [5:0] locToPos;
    input [5:0] loc;
    reg   [3:0] low;
    reg   [5:0] base;
    begin
      low  = (loc[3:0] > `PETG_QUAD_SPAN_MAX) ? `PETG_QUAD_SPAN_MAX : loc[3:0];
      base = `PETG_QUAD0_BASE;
      case (loc[5:4])
        2'h0: base = `PETG_QUAD0_BASE;
        2'h1: base = `PETG_QUAD1_BASE;
        2'h2: base = `PETG_QUAD2_BASE;
        default: base = `PETG_QUAD3_BASE;
      endcase
      locToPos = base + {2'b00, low};
    end
  endfunction

  // Half-period offset with wrap into the next pixel period.
  function [5:0] plusHalf;
    input [5:0] p;
    reg   [6:0] s;
    begin
      s = {1'b0, p} + `PETG_HALF_STEPS;
      if (s >= `PETG_STEPS_W7)
      begin
        s = s - `PETG_STEPS_W7;
      end
      plusHalf = s[5:0];
    end
  endfunction

  // High from start up to, not including, stop; a stop below start wraps the window.
  function inWindow;
    input [5:0] p;
    input [5:0] start;
    input [5:0] stop;
    begin
      if (start <= stop)
      begin
        inWindow = (p >= start) && (p < stop);
      end
      else
      begin
        inWindow = (p >= start) || (p < stop);
      end
    end
  endfunction

  petg_serial_rx u_serial_rx
  (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .clkEn       (clkEn),
    .serialClock (serialClock),
    .serialLoad  (serialLoad),
    .serialData  (serialData),
    .wrStrobe    (wrStrobe),
    .wrAddr      (wrAddr),
    .wrData      (wrData)
  );

  // Clearing digital standby restarts the divider, which is what lets software recover
  // a stable output clock after switching the divider back to zero.
  assign resync = !digitalStandbyReg;

  petg_phase_gen u_phase_gen
  (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .clkEn         (clkEn),
    .masterClockIn (masterClockIn),
    .divSel        (masterClockDivideReg),
    .resync        (resync),
    .finePos       (pos),
    .pixelStart    (pixelStart)
  );

  // Register writes land at the load rising edge of a complete frame.
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      refSampleLocReg      <= `PETG_RST_LOC;
      dataSampleLocReg     <= `PETG_RST_LOC;
      outputWordPhaseReg   <= `PETG_RST_LOC;
      outputClockPhaseReg  <= `PETG_RST_LOC;
      resetGateFallLocReg  <= `PETG_RST_LOC;
      horizARiseLocReg     <= `PETG_RST_LOC;
      horizADriveReg       <= `PETG_RST_DRV;
      horizBDriveReg       <= `PETG_RST_DRV;
      resetGateDriveReg    <= `PETG_RST_DRV;
      frontEndStandbyReg   <= 1'b1;
      digitalStandbyReg    <= 1'b1;
      amplifierGainReg     <= `PETG_RST_GAIN;
      masterClockDivideReg <= `PETG_RST_DIV;
    end
    else if (clkEn && wrStrobe)
    begin
      if (wrAddr == `PETG_ADDR_SAMPLE)
      begin
        refSampleLocReg     <= wrData[`PETG_F_REFLOC];
        dataSampleLocReg    <= wrData[`PETG_F_DATLOC];
        outputWordPhaseReg  <= wrData[`PETG_F_WORDPH];
        outputClockPhaseReg <= wrData[`PETG_F_OCLKPH];
      end
      else if (wrAddr == `PETG_ADDR_HCLK)
      begin
        resetGateFallLocReg <= wrData[`PETG_F_RGFALL];
        horizARiseLocReg    <= wrData[`PETG_F_HARISE];
      end
      else if (wrAddr == `PETG_ADDR_DRIVE)
      begin
        horizADriveReg    <= wrData[`PETG_F_HADRV];
        horizBDriveReg    <= wrData[`PETG_F_HBDRV];
        resetGateDriveReg <= wrData[`PETG_F_RESET_GATE_DRIVE_STRENGTH];
      end
      else if (wrAddr == `PETG_ADDR_STANDBY)
      begin
        frontEndStandbyReg <= wrData[`PETG_F_FRONT_END_STANDBY];
        digitalStandbyReg  <= wrData[`PETG_F_DIGITAL_STANDBY];
      end
      else if (wrAddr == `PETG_ADDR_GAIN)
      begin
        amplifierGainReg <= wrData[`PETG_F_GAIN];
      end
      else if (wrAddr == `PETG_ADDR_MASTER_CLOCK_DIVIDE)
      begin
        masterClockDivideReg <= wrData[`PETG_F_MASTER_CLOCK_DIVIDE];
      end
    end
  end

  assign rgFallPos   = locToPos(resetGateFallLocReg);
  assign haRisePos   = locToPos(horizARiseLocReg);
  assign haFallPos   = plusHalf(haRisePos);
  assign refPos      = locToPos(refSampleLocReg);
  assign datPos      = locToPos(dataSampleLocReg);
  assign wordRisePos = locToPos(outputWordPhaseReg);
  assign wordFallPos = plusHalf(wordRisePos);
  assign horizANext  = inWindow(pos, haRisePos, haFallPos);

  // Only the two low bits of the output clock phase field carry meaning.
  always @*
  begin
    oclkRisePos = `PETG_OCLK_P6;
    oclkFallPos = `PETG_OCLK_P26;
    case (outputClockPhaseReg[1:0])
      2'h0:
      begin
        oclkRisePos = `PETG_OCLK_P6;
        oclkFallPos = `PETG_OCLK_P26;
      end
      2'h1:
      begin
        oclkRisePos = `PETG_OCLK_P16;
        oclkFallPos = `PETG_OCLK_P36;
      end
      2'h2:
      begin
        oclkRisePos = `PETG_OCLK_P26;
        oclkFallPos = `PETG_OCLK_P6;
      end
      default:
      begin
        oclkRisePos = `PETG_OCLK_P36;
        oclkFallPos = `PETG_OCLK_P16;
      end
    endcase
  end

  // All edge outputs lag the fine position by one cycle, so their relative placement holds.
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      resetGatePulse    <= 1'b0;
      resetGateOe       <= 1'b0;
      horizClockA       <= 1'b0;
      horizClockAOe     <= 1'b0;
      horizClockB       <= 1'b1;
      horizClockBOe     <= 1'b0;
      horizADrive       <= `PETG_RST_DRV;
      horizBDrive       <= `PETG_RST_DRV;
      resetGateDrive    <= `PETG_RST_DRV;
      refSampleStrobe   <= 1'b0;
      levelSampleStrobe <= 1'b0;
      outputWord        <= 10'h000;
      outputWordWindow  <= 1'b0;
      pixelOutputClock  <= 1'b0;
      amplifierGain     <= `PETG_RST_GAIN;
      frontEndStandby   <= 1'b1;
      digitalStandby    <= 1'b1;
      finePosition      <= 6'h00;
    end
    else if (clkEn)
    begin
      resetGatePulse    <= inWindow(pos, `PETG_RG_RISE_POS, rgFallPos);
      horizClockA       <= horizANext;
      horizClockB       <= !horizANext;
      resetGateOe       <= (resetGateDriveReg != `PETG_DRV_OFF);
      horizClockAOe     <= (horizADriveReg != `PETG_DRV_OFF);
      horizClockBOe     <= (horizBDriveReg != `PETG_DRV_OFF);
      horizADrive       <= horizADriveReg;
      horizBDrive       <= horizBDriveReg;
      resetGateDrive    <= resetGateDriveReg;
      refSampleStrobe   <= (pos == refPos);
      levelSampleStrobe <= (pos == datPos);
      outputWordWindow  <= inWindow(pos, wordRisePos, wordFallPos);
      if (pos == wordRisePos)
      begin
        outputWord <= pixelDataIn;
      end
      pixelOutputClock  <= inWindow(pos, oclkRisePos, oclkFallPos);
      amplifierGain     <= amplifierGainReg;
      frontEndStandby   <= frontEndStandbyReg;
      digitalStandby    <= digitalStandbyReg;
      finePosition      <= pos;
    end
  end

endmodule

// file: testbench/petg_props.sv
`timescale 1ns/1ps
module petg_props
(
  input logic       core_clk,          // Core clock
  input logic       rst_b,             // Synchronous reset, low active
  input logic       clkEn,             // Clock enable
  input logic       serialLoad,        // Serial frame select
  input logic [5:0] finePosition,      // Fine position
  input logic       horizClockA,       // Horizontal clock A
  input logic       horizClockB,       // Horizontal clock B
  input logic       resetGatePulse,    // Reset-gate pulse
  input logic       resetGateOe,       // Reset-gate enable
  input logic       horizClockAOe,     // Horizontal A enable
  input logic       horizClockBOe,     // Horizontal B enable
  input logic [2:0] horizADrive,       // Horizontal A drive
  input logic [2:0] horizBDrive,       // Horizontal B drive
  input logic [2:0] resetGateDrive,    // Reset-gate drive
  input logic       refSampleStrobe,   // Reference strobe
  input logic       levelSampleStrobe, // Level strobe
  input logic [9:0] outputWord,        // Output word
  input logic       outputWordWindow,  // Output word window
  input logic       pixelOutputClock,  // Output pixel clock
  input logic       digitalStandby     // Digital standby
);
  logic [7:0] quietCnt_reg;
  logic       q;
  // Edge relations only hold once writes, freezes and divider changes have settled for a few periods.
  assign q = quietCnt_reg == 8'hC8;
  always @(posedge core_clk)
  begin
    if (!rst_b || !clkEn || !serialLoad || !digitalStandby)
      quietCnt_reg <= 8'h00;
    else if (!q)
      quietCnt_reg <= quietCnt_reg + 8'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b || !clkEn);
  hclk_complement_a: assert property (horizClockB == !horizClockA)
    else $error("horizontal clocks not complementary");
  fine_range_a: assert property (finePosition <= 6'h2F)
    else $error("fine position out of range");
  grid_step_a: assert property (q && finePosition != 6'h2F |=> finePosition == $past(finePosition) + 6'h01)
    else $error("fine position skipped");
  grid_wrap_a: assert property (q && finePosition == 6'h2F |=> finePosition == 6'h00)
    else $error("fine position did not wrap");
  hclk_width_a: assert property (q && $rose(horizClockA) |-> ##23 horizClockA ##1 !horizClockA)
    else $error("horizontal clock width wrong");
  word_window_a: assert property (q && $rose(outputWordWindow) |-> ##23 outputWordWindow ##1 !outputWordWindow)
    else $error("output word window width wrong");
  word_change_a: assert property (q && outputWord != $past(outputWord) |-> $rose(outputWordWindow))
    else $error("output word changed off phase");
  oclk_rise_a: assert property (q && $rose(pixelOutputClock) |-> finePosition inside {6'h06, 6'h10, 6'h1A, 6'h24})
    else $error("output clock rose off table");
  rg_rise_a: assert property (q && $rose(resetGatePulse) |-> finePosition == 6'h00)
    else $error("reset gate rose off position zero");
  drive_oe_a: assert property (q |-> resetGateOe == (resetGateDrive != 3'h0) && horizClockAOe == (horizADrive != 3'h0)
    && horizClockBOe == (horizBDrive != 3'h0))
    else $error("driver enable disagrees with strength");
  strobe_pulse_a: assert property (q && refSampleStrobe |=> !refSampleStrobe [*8])
    else $error("reference strobe too long");
  cover property (q && $rose(horizClockA));
  cover property (q && $rose(pixelOutputClock) && finePosition == 6'h24);
  cover property (q && levelSampleStrobe);
endmodule
bind petg_top petg_props i_props (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .serialLoad(serialLoad),
  .finePosition(finePosition), .horizClockA(horizClockA), .horizClockB(horizClockB), .resetGatePulse(resetGatePulse),
  .resetGateOe(resetGateOe), .horizClockAOe(horizClockAOe), .horizClockBOe(horizClockBOe), .horizADrive(horizADrive),
  .horizBDrive(horizBDrive), .resetGateDrive(resetGateDrive), .refSampleStrobe(refSampleStrobe),
  .levelSampleStrobe(levelSampleStrobe), .outputWord(outputWord), .outputWordWindow(outputWordWindow),
  .pixelOutputClock(pixelOutputClock), .digitalStandby(digitalStandby));

// file: testbench/petg_sensor_model.sv
`timescale 1ns/1ps
module petg_sensor_model
(
  input  logic       core_clk,      // Core clock
  input  logic [4:0] halfCycles,    // Master clock half period in core cycles
  output logic       masterClockIn, // Master clock to the block
  output logic [9:0] pixelDataIn    // Converted pixel word
);
  logic [4:0] cnt_reg;
  initial
  begin
    cnt_reg = 5'h00;
    masterClockIn = 1'b0;
    pixelDataIn = 10'h2A5;
  end
  // A new word arrives on every master rise, so a late capture shows up as a wrong word.
  always @(negedge core_clk)
  begin
    if (cnt_reg + 5'h01 >= halfCycles)
    begin
      cnt_reg <= 5'h00;
      masterClockIn <= !masterClockIn;
      if (!masterClockIn)
        pixelDataIn <= {pixelDataIn[8:0], !pixelDataIn[9]} ^ 10'h133;
    end
    else
      cnt_reg <= cnt_reg + 5'h01;
  end
endmodule

// file: testbench/pixel_edge_timing_generator_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module pixel_edge_timing_generator_tb;
  logic core_clk, rst_b, clkEn, masterClockIn, serialClock, serialLoad, serialData;
  logic resetGatePulse, resetGateOe, horizClockA, horizClockAOe, horizClockB, horizClockBOe;
  logic refSampleStrobe, levelSampleStrobe, outputWordWindow, pixelOutputClock, frontEndStandby, digitalStandby;
  logic [9:0] pixelDataIn, outputWord, amplifierGain;
  logic [2:0] horizADrive, horizBDrive, resetGateDrive;
  logic [5:0] finePosition;
  logic [4:0] halfCycles;
  int n_errors, check_count;
  logic [5:0] tab [4][5] = '{'{6'h1B, 6'h30, 6'h05, 6'h2A, 6'h14}, '{6'h3B, 6'h00, 6'h3B, 6'h00, 6'h08},
    '{6'h0F, 6'h2B, 6'h10, 6'h1F, 6'h25}, '{6'h00, 6'h1A, 6'h2A, 6'h35, 6'h31}};
  petg_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .masterClockIn(masterClockIn),
    .serialClock(serialClock), .serialLoad(serialLoad), .serialData(serialData), .pixelDataIn(pixelDataIn),
    .resetGatePulse(resetGatePulse), .resetGateOe(resetGateOe), .horizClockA(horizClockA),
    .horizClockAOe(horizClockAOe), .horizClockB(horizClockB), .horizClockBOe(horizClockBOe),
    .horizADrive(horizADrive), .horizBDrive(horizBDrive), .resetGateDrive(resetGateDrive),
    .refSampleStrobe(refSampleStrobe), .levelSampleStrobe(levelSampleStrobe), .outputWord(outputWord),
    .outputWordWindow(outputWordWindow), .pixelOutputClock(pixelOutputClock), .amplifierGain(amplifierGain),
    .frontEndStandby(frontEndStandby), .digitalStandby(digitalStandby), .finePosition(finePosition));
  petg_sensor_model i_model (.core_clk(core_clk), .halfCycles(halfCycles), .masterClockIn(masterClockIn),
    .pixelDataIn(pixelDataIn));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end
  function automatic logic [5:0] pos_of(input logic [5:0] l);
    return 6'h0C * l[5:4] + ((l[3:0] > 4'hB) ? 6'h0B : {2'h0, l[3:0]});
  endfunction
  function automatic logic [5:0] add24(input logic [5:0] s);
    return (s >= 6'h18) ? s - 6'h18 : s + 6'h18;
  endfunction
  function automatic logic inw(input logic [5:0] p, input logic [5:0] s, input logic [5:0] e);
    return (s == e) ? 1'b0 : (s < e) ? (p >= s && p < e) : (p >= s || p < e);
  endfunction
  task automatic send(input logic [7:0] a, input logic [23:0] d, input int nb);
    logic [31:0] f;
    f = {a, d};
    serialLoad = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      serialClock = 1'b0;
      serialData = f[31 - i];
      repeat (2) @(negedge core_clk);
      serialClock = 1'b1;
      repeat (2) @(negedge core_clk);
    end
    serialLoad = 1'b1;
    serialData = !serialData;
    repeat (4) @(negedge core_clk);
  endtask
  // Programs one row of locations with output clock code oc and judges a whole pixel period.
  task automatic cfg_walk(input int k, input logic [1:0] oc);
    logic [5:0] p, rg, ha, wp, r, f;
    send(8'h03, {12'h000, tab[k][1], tab[k][0]}, 32);
    send(8'h02, {4'h0, oc, tab[k][4], tab[k][3], tab[k][2]}, 32);
    rg = pos_of(tab[k][0]);
    ha = pos_of(tab[k][1]);
    wp = pos_of(tab[k][4]);
    r = (oc == 2'h0) ? 6'h06 : (oc == 2'h1) ? 6'h10 : (oc == 2'h2) ? 6'h1A : 6'h24;
    f = (r >= 6'h14) ? r - 6'h14 : r + 6'h14;
    repeat (48)
    begin
      @(negedge core_clk);
      p = finePosition;
      `CHK(resetGatePulse, inw(p, 6'h00, rg))
      `CHK(horizClockA, inw(p, ha, add24(ha)))
      `CHK(refSampleStrobe, p == pos_of(tab[k][2]))
      `CHK(levelSampleStrobe, p == pos_of(tab[k][3]))
      `CHK(outputWordWindow, inw(p, wp, add24(wp)))
      `CHK(pixelOutputClock, inw(p, r, f))
      if (p == wp)
        `CHK(outputWord, pixelDataIn)
    end
  endtask
  task automatic t_drive;
    send(8'h04, {15'h0000, 3'h3, 3'h0, 3'h7}, 32);
    `CHK({horizADrive, horizBDrive, resetGateDrive}, 9'h1C3)
    `CHK({horizClockAOe, horizClockBOe, resetGateOe}, 3'h5)
    send(8'h04, {15'h0000, 3'h0, 3'h5, 3'h0}, 31);
    `CHK(horizBDrive, 3'h0)
    send(8'h04, {15'h0000, 3'h0, 3'h5, 3'h0}, 32);
    `CHK({horizClockAOe, horizClockBOe, resetGateOe}, 3'h2)
    `CHK(horizClockB, !horizClockA)
    send(8'h0E, 24'h00_02A5, 32);
    `CHK(amplifierGain, 10'h2A5)
  endtask
  task automatic t_edges;
    for (int k = 0; k < 4; k++)
      cfg_walk(k, k[1:0]);
  endtask
  task automatic t_divide;
    for (int d = 1; d < 4; d++)
    begin
      halfCycles = 5'(24 / (d + 1));
      send(8'hD5, 24'(d), 32);
      repeat (250) @(negedge core_clk);
      cfg_walk(d, 2'(d));
    end
    halfCycles = 5'h18;
    send(8'hD5, 24'h00_0000, 32);
    send(8'h05, 24'h00_0000, 32);
    `CHK({frontEndStandby, digitalStandby, finePosition}, 8'h00)
    send(8'h05, 24'h00_0003, 32);
    repeat (250) @(negedge core_clk);
    cfg_walk(0, 2'h3);
  endtask
  task automatic t_freeze;
    logic [5:0] p;
    clkEn = 1'b0;
    @(negedge core_clk);
    p = finePosition;
    repeat (5) @(negedge core_clk);
    `CHK(finePosition, p)
    clkEn = 1'b1;
    repeat (250) @(negedge core_clk);
    cfg_walk(1, 2'h1);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    close_out();
  end
  initial
  begin
    n_errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    clkEn = 1'b1;
    serialClock = 1'b0;
    serialLoad = 1'b1;
    serialData = 1'b0;
    halfCycles = 5'h18;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    `CHK({horizClockB, frontEndStandby, digitalStandby, horizClockA, resetGateOe}, 5'h1C)
    t_drive();
    t_edges();
    t_divide();
    t_freeze();
    close_out();
  end
endmodule
